// >>> logic/uoe_ep0_ctrl.sv
// OUT endpoint 0 control register and handshake logic over APB
`timescale 1ns/1ns
`default_nettype none
`include "uoe_consts.svh"
module uoe_ep0_ctrl
	import uoe_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        global_out_nak_status,
	input  wire logic [1:0]  in_ep0_size_code,
	input  wire logic        token_out,
	input  wire logic        token_setup,
	input  wire logic        token_crc_ok,
	input  wire logic        rx_fifo_ready,
	input  wire logic        transfer_done,
	output logic             endpoint_enable,
	output logic             stall_out,
	output logic             snoop_out,
	output logic             nak_hold_status,
	output logic             hs_valid,
	output logic [1:0]       hs_code,
	output logic             data_accept
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        enable;
		logic        stall;
		logic        snoop;
		logic        nak_hold;
		logic [1:0]  size_code;
		logic [31:0] rdata;
		logic        ready;
		logic        slverr;
		logic        hs_valid;
		logic [1:0]  hs_code;
		logic        accept;
	} uoe_state_t;

	uoe_state_t st;
	uoe_state_t next_st;
	uoe_hs_t    hs;

	function automatic logic [31:0] read_word(input uoe_state_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`UOE_BIT_ENABLE]   = s.enable;
		// Disable request and both strobes stay zero on read
		w[`UOE_BIT_DISABLE_REQ] = 1'b0;
		w[`UOE_BIT_STALL]    = s.stall;
		w[`UOE_BIT_SNOOP]    = s.snoop;
		w[`UOE_BIT_TYPE_HI:`UOE_BIT_TYPE_LO] = `UOE_TYPE_CONTROL;
		w[`UOE_BIT_NAK_HOLD] = s.nak_hold;
		w[`UOE_BIT_ACTIVE]   = 1'b1;
		w[1:0]               = s.size_code;
		return w;
	endfunction

	uoe_handshake u_hs (
		.stall                 (st.stall),
		.global_out_nak_status (global_out_nak_status),
		.nak_hold_status       (st.nak_hold),
		.rx_fifo_ready         (rx_fifo_ready),
		.crc_ok                (token_crc_ok),
		.snoop                 (st.snoop),
		.setup                 (token_setup),
		.hs                    (hs)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic acc;
	logic hit;
	logic wr;
	logic full_word;

	always_comb begin
		next_st = st;
		acc = psel && penable && !st.ready;
		hit = (paddr == `UOE_OUT_EP0_CONTROL_ADDR);
		full_word = (pstrb == 4'hF);
		wr = acc && pwrite && hit && full_word;
		next_st.ready = acc;
		next_st.slverr = acc && (!hit || (pwrite && !full_word));
		next_st.rdata = (acc && !pwrite && hit) ?
			read_word(st) : 32'h0000_0000;
		// Mirror is registered, so it lags the IN side by one cycle
		next_st.size_code = in_ep0_size_code;
		if (wr) begin
			// Software can only set enable, never clear it
			if (pwdata[`UOE_BIT_ENABLE]) begin
				next_st.enable = 1'b1;
			end
			// Software may set STALL but not clear it
			if (pwdata[`UOE_BIT_STALL]) begin
				next_st.stall = 1'b1;
			end
			next_st.snoop = pwdata[`UOE_BIT_SNOOP];
			// Set wins if both strobes are written at once
			if (pwdata[`UOE_BIT_CLEAR_NAK]) begin
				next_st.nak_hold = 1'b0;
			end
			if (pwdata[`UOE_BIT_SET_NAK]) begin
				next_st.nak_hold = 1'b1;
			end
		end
		if (transfer_done) begin
			next_st.enable = 1'b0;
		end
		// SETUP clears STALL; a software set in that cycle still wins
		if (token_setup && !(wr && pwdata[`UOE_BIT_STALL])) begin
			next_st.stall = 1'b0;
		end
		next_st.hs_valid = token_out || token_setup;
		next_st.hs_code = (token_out || token_setup) ? hs : UOE_HS_NONE;
		next_st.accept = (token_out || token_setup) && hs == UOE_HS_ACK;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata          = st.rdata;
	assign pready          = st.ready;
	assign pslverr         = st.slverr;
	assign endpoint_enable = st.enable;
	assign stall_out       = st.stall;
	assign snoop_out       = st.snoop;
	assign nak_hold_status = st.nak_hold;
	assign hs_valid        = st.hs_valid;
	assign hs_code         = st.hs_code;
	assign data_accept     = st.accept;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_enable_set;
		wr && pwdata[31] |=> st.enable || $past(transfer_done);
	endproperty
	a_enable_set: assert property (p_enable_set)
		else $error("enable lost");

	property p_enable_clr;
		transfer_done |=> !endpoint_enable;
	endproperty
	a_enable_clr: assert property (p_enable_clr)
		else $error("enable kept");

	property p_read_fixed;
		pready && !pslverr && prdata != 32'h0 |->
			prdata[30] == 1'b0 && prdata[27:26] == 2'h0 &&
			prdata[19:18] == 2'h0 && prdata[15];
	endproperty
	a_read_fixed: assert property (p_read_fixed)
		else $error("fixed bits");

	property p_active;
		pready && !pslverr && !$past(pwrite) |->
			prdata[15] && prdata[30] == 1'b0;
	endproperty
	a_active: assert property (p_active)
		else $error("active flag");

	property p_strobe_zero;
		pready && !pslverr && !$past(pwrite) |->
			prdata[27:26] == 2'h0 && prdata[19:18] == 2'h0;
	endproperty
	a_strobe_zero: assert property (p_strobe_zero)
		else $error("strobe read");

	property p_size_mirror;
		pready && !pslverr && !$past(pwrite) |->
			prdata[1:0] == $past(in_ep0_size_code, 2);
	endproperty
	a_size_mirror: assert property (p_size_mirror)
		else $error("size code");

	property p_set_nak;
		wr && pwdata[27] |=> nak_hold_status;
	endproperty
	a_set_nak: assert property (p_set_nak)
		else $error("set nak");

	property p_clear_nak;
		wr && pwdata[26] && !pwdata[27] |=> !nak_hold_status;
	endproperty
	a_clear_nak: assert property (p_clear_nak)
		else $error("clear nak");

	property p_refuse;
		acc && pwrite && !full_word && !transfer_done && !token_setup |=>
			$stable(endpoint_enable) && $stable(stall_out) &&
			$stable(snoop_out) && $stable(nak_hold_status);
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("refused write acted");

	property p_stall_hs;
		token_out && !token_setup && st.stall |=>
			hs_code == UOE_HS_STALL && hs_valid;
	endproperty
	a_stall_hs: assert property (p_stall_hs)
		else $error("no stall");

	property p_stall_set;
		wr && pwdata[21] |=> stall_out;
	endproperty
	a_stall_set: assert property (p_stall_set)
		else $error("stall not set");

	property p_setup_clr;
		token_setup && !wr |=> !stall_out;
	endproperty
	a_setup_clr: assert property (p_setup_clr)
		else $error("stall kept");

	property p_stall_keep;
		stall_out && !token_setup |=> stall_out;
	endproperty
	a_stall_keep: assert property (p_stall_keep)
		else $error("stall dropped");

	property p_setup_ok;
		token_setup && token_crc_ok |=> hs_code == UOE_HS_ACK && data_accept;
	endproperty
	a_setup_ok: assert property (p_setup_ok)
		else $error("setup refused");

	property p_nak_hold;
		token_out && !token_setup && !st.stall && st.nak_hold &&
			(token_crc_ok || st.snoop) |=> hs_code == UOE_HS_NAK;
	endproperty
	a_nak_hold: assert property (p_nak_hold)
		else $error("no nak");

	property p_fifo;
		token_out && !token_setup && !st.stall && !st.nak_hold &&
			!global_out_nak_status && token_crc_ok && rx_fifo_ready
			|=> data_accept;
	endproperty
	a_fifo: assert property (p_fifo)
		else $error("not accepted");

	property p_hs_once;
		!token_out && !token_setup |=> !hs_valid;
	endproperty
	a_hs_once: assert property (p_hs_once)
		else $error("answer without token");

	property p_nak_ro;
		!(wr && (pwdata[27] || pwdata[26])) |=> $stable(nak_hold_status);
	endproperty
	a_nak_ro: assert property (p_nak_ro)
		else $error("nak moved");

	property p_snoop_wr;
		wr |=> snoop_out == $past(pwdata[20]);
	endproperty
	a_snoop_wr: assert property (p_snoop_wr)
		else $error("snoop not written");

	property p_crc;
		token_out && !token_setup && !st.stall && !token_crc_ok &&
			!st.snoop |=> hs_code == UOE_HS_NONE;
	endproperty
	a_crc: assert property (p_crc)
		else $error("bad crc taken");

	// ----------------------------------------------------------------
	// Cover
	// ----------------------------------------------------------------
	c_stall: cover property (token_out && st.stall);
	c_setup: cover property (token_setup && st.stall);
	c_nak: cover property (wr && pwdata[27]);
	c_snoop: cover property (token_out && st.snoop && !token_crc_ok);
	c_fifo_nak: cover property (token_out && !rx_fifo_ready);
endmodule
`default_nettype wire

// >>> logic/uoe_consts.svh
// Register offset, field positions and reset value for OUT endpoint 0
`ifndef UOE_CONSTS_SVH
`define UOE_CONSTS_SVH

`define UOE_OUT_EP0_CONTROL_ADDR  12'hB00
`define UOE_OUT_EP0_CONTROL_RESET 32'h0000_8000
`define UOE_BIT_ENABLE            31
`define UOE_BIT_DISABLE_REQ       30
`define UOE_BIT_SET_NAK           27
`define UOE_BIT_CLEAR_NAK         26
`define UOE_BIT_STALL             21
`define UOE_BIT_SNOOP             20
`define UOE_BIT_TYPE_HI           19
`define UOE_BIT_TYPE_LO           18
`define UOE_BIT_NAK_HOLD          17
`define UOE_BIT_ACTIVE            15
`define UOE_TYPE_CONTROL          2'h0

`endif

// >>> logic/uoe_pkg.sv
// Types shared by the OUT endpoint 0 control block
package uoe_pkg;
	typedef enum logic [1:0] {
		UOE_HS_NONE,
		UOE_HS_ACK,
		UOE_HS_NAK,
		UOE_HS_STALL
	} uoe_hs_t;
endpackage

// >>> logic/uoe_handshake.sv
// Handshake selection for OUT and SETUP tokens on endpoint 0
`timescale 1ns/1ns
`default_nettype none
module uoe_handshake
	import uoe_pkg::*;
(
	input  wire logic    stall,
	input  wire logic    global_out_nak_status,
	input  wire logic    nak_hold_status,
	input  wire logic    rx_fifo_ready,
	input  wire logic    crc_ok,
	input  wire logic    snoop,
	input  wire logic    setup,
	output var uoe_hs_t  hs
);
	always_comb begin
		// SETUP with good CRC is always ACKed, even when stalled or NAK is held; a bad-CRC SETUP gets no handshake
		if (setup) begin
			hs = crc_ok ? UOE_HS_ACK : UOE_HS_NONE;
		end else if (stall) begin
			hs = UOE_HS_STALL;
		end else if (!crc_ok && !snoop) begin
			hs = UOE_HS_NONE;
		end else if (global_out_nak_status || nak_hold_status) begin
			hs = UOE_HS_NAK;
		end else begin
			hs = rx_fifo_ready ? UOE_HS_ACK : UOE_HS_NAK;
		end
	end
endmodule
`default_nettype wire

// >>> verification/uoe_host_model.sv
// Host model issuing OUT and SETUP tokens to endpoint 0
`timescale 1ns/1ns
`default_nettype none
module uoe_host_model (
	input  wire logic pclk,
	output logic      token_out,
	output logic      token_setup,
	output logic      token_crc_ok
);
	initial begin
		token_out = 1'b0;
		token_setup = 1'b0;
		token_crc_ok = 1'b0;
	end
	// One-cycle token; crc line flips once idle so no stale value helps
	task automatic send(input logic setup, input logic crc);
		token_out <= ~setup;
		token_setup <= setup;
		token_crc_ok <= crc;
		@(posedge pclk);
		token_out <= 1'b0;
		token_setup <= 1'b0;
		token_crc_ok <= ~crc;
	endtask
endmodule
`default_nettype wire

// >>> verification/tb_uoe_ep0_ctrl.sv
// Testbench for the OUT endpoint 0 control block
`timescale 1ns/1ns
`default_nettype none
`include "uoe_consts.svh"
module tb_uoe_ep0_ctrl
	import uoe_pkg::*;
;
	localparam logic [11:0] A = `UOE_OUT_EP0_CONTROL_ADDR;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        global_out_nak_status, token_out, token_setup, rerr;
	logic        token_crc_ok, rx_fifo_ready, transfer_done, stall_out;
	logic        endpoint_enable, snoop_out, nak_hold_status, hs_valid;
	logic        data_accept;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0]  pstrb;
	logic [1:0]  in_ep0_size_code, hs_code;
	int          n_fail, checks;
	uoe_ep0_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .global_out_nak_status,
		.in_ep0_size_code, .token_out, .token_setup, .token_crc_ok,
		.rx_fifo_ready, .transfer_done, .endpoint_enable, .stall_out,
		.snoop_out, .nak_hold_status, .hs_valid, .hs_code, .data_accept);
	uoe_host_model host (.pclk, .token_out, .token_setup, .token_crc_ok);
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic report_and_stop();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask
	// Holds the request until pready is seen at a rising edge, giving up after 20 edges
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 20) n_fail++;
	endtask
	task automatic tok(input logic s, c, input uoe_hs_t e);
		host.send(s, c);
		@(posedge pclk);
		chk("hs_valid", 32'(hs_valid), 1);
		chk("hs_code", 32'(hs_code), 32'(e));
		chk("accept", 32'(data_accept), 32'(e == UOE_HS_ACK));
	endtask
	function automatic logic [31:0] lv();
		return 32'({endpoint_enable, stall_out, snoop_out, nak_hold_status});
	endfunction
	task automatic t_fixed();
		for (int i = 0; i < 4; i++) begin
			in_ep0_size_code <= 2'(i);
			@(posedge pclk);
			apb(1'b0, A, 32'h0, 4'h0);
			chk("reg", rdat, `UOE_OUT_EP0_CONTROL_RESET | 32'(i));
			chk("err", 32'(rerr), 0);
		end
	endtask
	task automatic t_refuse();
		apb(1'b1, A, 32'hFFFFFFFF, 4'h7);
		chk("err", 32'(rerr), 1);
		chk("lv", lv(), 0);
		apb(1'b0, 12'hB04, 32'h0, 4'h0);
		chk("unmapped", {rdat[31:1], rerr}, 1);
	endtask
	task automatic t_tokens();
		apb(1'b1, A, 32'hFFFFFFFF, 4'hF);
		apb(1'b0, A, 32'h0, 4'h0);
		chk("all ones", rdat, 32'h80328003);
		chk("lv", lv(), 32'hF);
		tok(1'b0, 1'b1, UOE_HS_STALL);
		tok(1'b1, 1'b1, UOE_HS_ACK);
		chk("stall", 32'(stall_out), 0);
		tok(1'b0, 1'b1, UOE_HS_NAK);
		apb(1'b1, A, 32'h04100000, 4'hF);
		chk("lv", lv(), 32'hA);
		tok(1'b0, 1'b1, UOE_HS_ACK);
		tok(1'b0, 1'b0, UOE_HS_ACK);
		global_out_nak_status <= 1'b1;
		tok(1'b0, 1'b1, UOE_HS_NAK);
		global_out_nak_status <= 1'b0;
		rx_fifo_ready <= 1'b0;
		tok(1'b0, 1'b1, UOE_HS_NAK);
		rx_fifo_ready <= 1'b1;
		apb(1'b1, A, 32'h0, 4'hF);
		chk("lv", lv(), 32'h8);
		tok(1'b0, 1'b0, UOE_HS_NONE);
		transfer_done <= 1'b1;
		@(posedge pclk);
		transfer_done <= 1'b0;
		@(posedge pclk);
		chk("enable", 32'(endpoint_enable), 0);
		apb(1'b1, A, 32'h00200000, 4'hF);
		tok(1'b0, 1'b1, UOE_HS_STALL);
		tok(1'b1, 1'b0, UOE_HS_NONE);
		chk("stall", 32'(stall_out), 0);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, transfer_done} = '0;
		{paddr, pwdata, pstrb, in_ep0_size_code} = '0;
		global_out_nak_status = 1'b0;
		rx_fifo_ready = 1'b1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_fixed();
		t_refuse();
		t_tokens();
		report_and_stop();
	end
	initial begin
		#(40 * 3000);
		n_fail++;
		report_and_stop();
	end
endmodule
`default_nettype wire
